/* File: logic/pmc_defines.svh */
// Register offsets, field positions, reset values and timing counts of the power mode controller.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_CTRL_OFS      12'h000
`define PMC_STATUS_OFS    12'h004
`define PMC_WAKE_CFG_OFS  12'h008
`define PMC_INCR_OFS      12'h00C
`define PMC_RTC_LO_OFS    12'h010
`define PMC_RTC_HI_OFS    12'h014
`define PMC_CMP_LO_OFS    12'h018
`define PMC_CMP_HI_OFS    12'h01C
`define PMC_SLPCFG_OFS    12'h020
`define PMC_DSMEM_OFS     12'h080
`define PMC_CTRL_SLEEP    0
`define PMC_CFG_PIN_LSB   0
`define PMC_CFG_POL       4
`define PMC_CFG_PIN_EN    5
`define PMC_CFG_TMR_EN    6
`define PMC_CFG_LP_EN     7
`define PMC_SLPCFG_RST    32'h0000_0000
`define PMC_INCR_RST      32'h0000_0280
`define PMC_CMP_RST       64'hFFFF_FFFF_FFFF_FFFF
`define PMC_LP_HZ         31250
`define PMC_MAIN_HZ       20000000
`define PMC_LP_DIV        (`PMC_MAIN_HZ / `PMC_LP_HZ)
`endif

/* File: logic/pmc_pkg.sv */
// Types shared by the power mode controller.
package pmc_pkg;
    typedef enum logic [2:0] {
        ST_AWAKE   = 3'b000,
        ST_CLK_OFF = 3'b001,
        ST_SUP_OFF = 3'b010,
        ST_ASLEEP  = 3'b011,
        ST_SUP_ON  = 3'b100,
        ST_CLK_ON  = 3'b101
    } pm_state_t;
endpackage

/* File: logic/power_mode_controller.sv */
// APB power mode controller with real-time counter, wake logic and deep-sleep memory.
// Overview of operation
// - Quiescent in asleep, running in awake, stepping through intermediate states.
// - A software sleep write to control starts the awake-to-asleep sequence.
// - Pin or timer wake request starts the asleep-to-awake sequence.
// - Wake stimulus acted on only in the asleep state.
// - Wake stimulus during descent is remembered and acted on at asleep.
// - Wake on chosen pin asserted or deasserted, pin and polarity programmable.
// - Wake when the 64-bit counter reaches the programmed value.
// - Awake, the counter counts main oscillator ticks.
// - Asleep, the counter optionally moves to the 31,250 Hz clock.
// - On low-power ticks a programmable increment is added.
// - Asleep powers down the digital node; awake runs everything.
// - 128 bytes of deep-sleep memory retained while asleep.
// - Power-good loss during either transition issues a system reset.
// - Watchdog enabled only while awake.
`include "pmc_defines.svh"

module power_mode_controller (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] wake_pins,
    input  wire logic        core_pgood,
    input  wire logic        second_buck_supply_pgood,
    output logic             core_supply_en,
    output logic             node_clk_en,
    output logic             node_reset,
    output logic             sys_reset,
    output logic             watchdog_en,
    output logic [31:0]      sleep_cfg
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    pmc_pkg::pm_state_t state_q;
    logic [7:0]  cfg_q;
    logic [31:0] incr_q;
    logic [63:0] cmp_q;
    logic [63:0] rtc_q;
    logic [31:0] slpcfg_q;
    logic [31:0] dsmem_q [0:31];
    logic        wake_pend_q;
    logic        sleep_req_q;
    logic [9:0]  lp_cnt_q;
    logic        pgood_fail_q;

    logic acc;
    logic wr;
    logic rd_ok;
    assign acc = psel && penable;
    assign wr  = acc && pwrite;

    function automatic logic is_dsmem(input logic [11:0] a);
        return a[11:7] == 5'(`PMC_DSMEM_OFS >> 7);
    endfunction

    function automatic logic known_addr(input logic [11:0] a);
        return is_dsmem(a) || (a <= `PMC_SLPCFG_OFS && a[1:0] == 2'b00);
    endfunction
    assign rd_ok = known_addr(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q    <= 8'h00;
            incr_q   <= `PMC_INCR_RST;
            cmp_q    <= `PMC_CMP_RST;
            slpcfg_q <= `PMC_SLPCFG_RST;
        end else if (wr) begin
            case (paddr)
                `PMC_WAKE_CFG_OFS: cfg_q    <= pwdata[7:0];
                `PMC_INCR_OFS:     incr_q   <= pwdata;
                `PMC_CMP_LO_OFS:   cmp_q    <= {cmp_q[63:32], pwdata};
                `PMC_CMP_HI_OFS:   cmp_q    <= {pwdata, cmp_q[31:0]};
                `PMC_SLPCFG_OFS:   slpcfg_q <= pwdata;
                default: ;
            endcase
        end
    end

    // Retained memory words.
    // Flip-flops keep the memory through sleep; only reset of the whole block clears it.
    generate
        for (genvar i = 0; i < 32; i++) begin : g_dsmem
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dsmem_q[i] <= 32'h0000_0000;
                end else if (wr && is_dsmem(paddr) && paddr[6:2] == 5'(i)) begin
                    dsmem_q[i] <= pwdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known_addr(paddr);
            if (psel && !penable && !pwrite) begin
                if (is_dsmem(paddr)) begin
                    prdata <= dsmem_q[paddr[6:2]];
                end else begin
                    case (paddr)
                        `PMC_CTRL_OFS:     prdata <= {31'h0, sleep_req_q};
                        `PMC_STATUS_OFS:   prdata <= {27'h0, pgood_fail_q, wake_pend_q, 3'b000} | {29'h0, state_q};
                        `PMC_WAKE_CFG_OFS: prdata <= {24'h0, cfg_q};
                        `PMC_INCR_OFS:     prdata <= incr_q;
                        `PMC_RTC_LO_OFS:   prdata <= rtc_q[31:0];
                        `PMC_RTC_HI_OFS:   prdata <= rtc_q[63:32];
                        `PMC_CMP_LO_OFS:   prdata <= cmp_q[31:0];
                        `PMC_CMP_HI_OFS:   prdata <= cmp_q[63:32];
                        `PMC_SLPCFG_OFS:   prdata <= slpcfg_q;
                        default:           prdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Real-time counter
    // ------------------------------------------------------------
    logic lp_sel;
    logic lp_tick;
    assign lp_sel  = cfg_q[`PMC_CFG_LP_EN] && state_q == pmc_pkg::ST_ASLEEP;
    assign lp_tick = lp_cnt_q == 10'(`PMC_LP_DIV - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_cnt_q <= 10'h000;
        end else if (!lp_sel || lp_tick) begin
            lp_cnt_q <= 10'h000;
        end else begin
            lp_cnt_q <= lp_cnt_q + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_q <= 64'h0000_0000_0000_0000;
        end else if (wr && paddr == `PMC_RTC_LO_OFS) begin
            rtc_q <= {rtc_q[63:32], pwdata};
        end else if (wr && paddr == `PMC_RTC_HI_OFS) begin
            rtc_q <= {pwdata, rtc_q[31:0]};
        end else if (lp_sel) begin
            if (lp_tick) begin
                rtc_q <= rtc_q + {32'h0, incr_q};
            end
        end else begin
            rtc_q <= rtc_q + 64'h1;
        end
    end

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    logic pin_hit;
    logic tmr_hit;
    logic wake_ev;
    assign pin_hit = cfg_q[`PMC_CFG_PIN_EN] && (wake_pins[cfg_q[3:0]] == cfg_q[`PMC_CFG_POL]);
    assign tmr_hit = cfg_q[`PMC_CFG_TMR_EN] && rtc_q >= cmp_q;
    assign wake_ev = pin_hit || tmr_hit;

    // Remember early stimulus.
    // A stimulus during descent is latched; the set wins over the clear on leaving asleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_pend_q <= 1'b0;
        end else if (wake_ev && state_q != pmc_pkg::ST_AWAKE) begin
            wake_pend_q <= state_q inside {pmc_pkg::ST_CLK_OFF, pmc_pkg::ST_SUP_OFF, pmc_pkg::ST_ASLEEP};
        end else if (state_q == pmc_pkg::ST_ASLEEP || state_q == pmc_pkg::ST_AWAKE) begin
            wake_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_req_q <= 1'b0;
        end else if (wr && paddr == `PMC_CTRL_OFS && pwdata[`PMC_CTRL_SLEEP]
                     && state_q == pmc_pkg::ST_AWAKE) begin
            sleep_req_q <= 1'b1;
        end else if (state_q != pmc_pkg::ST_AWAKE) begin
            sleep_req_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    logic in_trans;
    assign in_trans = state_q != pmc_pkg::ST_AWAKE && state_q != pmc_pkg::ST_ASLEEP;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pmc_pkg::ST_AWAKE;
        end else if (in_trans && !second_buck_supply_pgood) begin
            state_q <= pmc_pkg::ST_AWAKE;
        end else begin
            unique case (state_q)
                pmc_pkg::ST_AWAKE:   if (sleep_req_q) state_q <= pmc_pkg::ST_CLK_OFF;
                pmc_pkg::ST_CLK_OFF: state_q <= pmc_pkg::ST_SUP_OFF;
                pmc_pkg::ST_SUP_OFF: if (!core_pgood) state_q <= pmc_pkg::ST_ASLEEP;
                pmc_pkg::ST_ASLEEP:  if (wake_ev || wake_pend_q) state_q <= pmc_pkg::ST_SUP_ON;
                pmc_pkg::ST_SUP_ON:  if (core_pgood) state_q <= pmc_pkg::ST_CLK_ON;
                pmc_pkg::ST_CLK_ON:  state_q <= pmc_pkg::ST_AWAKE;
                default:             state_q <= pmc_pkg::ST_AWAKE;
            endcase
        end
    end

    // Power-good loss reset.
    // Core supply falling is expected on the way down, so only the always-on supply is watched there.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset    <= 1'b0;
            pgood_fail_q <= 1'b0;
        end else begin
            sys_reset <= (in_trans && !second_buck_supply_pgood)
                      || (state_q == pmc_pkg::ST_CLK_ON && !core_pgood);
            if (sys_reset) begin
                pgood_fail_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_supply_en <= 1'b1;
            node_clk_en    <= 1'b1;
            node_reset     <= 1'b0;
            watchdog_en    <= 1'b1;
            sleep_cfg      <= `PMC_SLPCFG_RST;
        end else begin
            core_supply_en <= !(state_q inside {pmc_pkg::ST_SUP_OFF, pmc_pkg::ST_ASLEEP});
            node_clk_en    <= state_q == pmc_pkg::ST_AWAKE || state_q == pmc_pkg::ST_CLK_ON;
            node_reset     <= state_q == pmc_pkg::ST_ASLEEP || state_q == pmc_pkg::ST_SUP_OFF;
            watchdog_en    <= state_q == pmc_pkg::ST_AWAKE;
            sleep_cfg      <= slpcfg_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence sleep_write_s;
        wr && paddr == `PMC_CTRL_OFS && pwdata[0] && state_q == pmc_pkg::ST_AWAKE;
    endsequence

    sleep_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_write_s |-> ##2 state_q == pmc_pkg::ST_CLK_OFF) else $error("sleep not started");
    wake_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == pmc_pkg::ST_SUP_ON && $past(state_q) != pmc_pkg::ST_SUP_ON
        |-> $past(state_q) == pmc_pkg::ST_ASLEEP) else $error("wake from wrong state");
    wake_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == pmc_pkg::ST_ASLEEP && wake_ev && second_buck_supply_pgood
        |=> state_q == pmc_pkg::ST_SUP_ON) else $error("wake ignored");
    pend_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == pmc_pkg::ST_SUP_OFF && wake_ev |=> wake_pend_q) else $error("early wake lost");
    rtc_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        !lp_sel && !wr |=> rtc_q == $past(rtc_q) + 64'h1) else $error("counter not counting");
    lp_incr_a: assert property (@(posedge pclk) disable iff (!presetn)
        lp_sel && lp_tick && !wr |=> rtc_q == $past(rtc_q) + {32'h0, $past(incr_q)}) else $error("bad increment");
    lp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        lp_sel && !lp_tick && !wr |=> rtc_q == $past(rtc_q)) else $error("counter moved off tick");
    pgood_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_trans && !second_buck_supply_pgood |=> sys_reset) else $error("no reset on power loss");
    wdog_awake_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 watchdog_en == ($past(state_q) == pmc_pkg::ST_AWAKE)) else $error("watchdog wrong");
    node_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == pmc_pkg::ST_ASLEEP [*2] |-> !core_supply_en && !node_clk_en) else $error("node powered asleep");
    tmr_ge_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == pmc_pkg::ST_ASLEEP && cfg_q[`PMC_CFG_TMR_EN] && rtc_q >= cmp_q && second_buck_supply_pgood
        |=> state_q == pmc_pkg::ST_SUP_ON) else $error("timer compare missed");
    pin_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == pmc_pkg::ST_ASLEEP && cfg_q[`PMC_CFG_PIN_EN] && second_buck_supply_pgood
        && wake_pins[cfg_q[3:0]] == cfg_q[`PMC_CFG_POL]
        |=> state_q == pmc_pkg::ST_SUP_ON) else $error("pin wake missed");
    down_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == pmc_pkg::ST_ASLEEP && $past(state_q) != pmc_pkg::ST_ASLEEP
        |-> $past(state_q) == pmc_pkg::ST_SUP_OFF) else $error("step order broken");
endmodule // power_mode_controller

/* File: tb/test_power_mode_controller.sv */
// Self-checking bench for the power mode controller.
`include "pmc_defines.svh"
module test_power_mode_controller;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] LP_INC = 32'h0010_0000;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] sleep_cfg;
    logic        pready;
    logic        pslverr;
    logic        core_supply_en;
    logic        node_clk_en;
    logic        node_reset;
    logic        sys_reset;
    logic        watchdog_en;
    logic [15:0] wake_pins = 16'h0000;
    logic        core_pgood = 1'b1;
    logic        buck_pgood = 1'b1;
    logic [31:0] seed = 32'd24352;
    logic [31:0] r;
    logic [31:0] t1;
    logic        e;
    int          err_total = 0;
    int          tests_run = 0;
    int          pin;
    int          pol;
    int          n;
    logic [31:0] dsm [32];

    always #25 pclk = ~pclk;

    power_mode_controller u_power_mode_controller (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .wake_pins                (wake_pins),
        .core_pgood               (core_pgood),
        .second_buck_supply_pgood (buck_pgood),
        .core_supply_en           (core_supply_en),
        .node_clk_en              (node_clk_en),
        .node_reset               (node_reset),
        .sys_reset                (sys_reset),
        .watchdog_en              (watchdog_en),
        .sleep_cfg                (sleep_cfg)
    );

    // ----------------------------------------------------------------
    // Bus tasks, comparison and closing report
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The request is held until pready is seen high; a stuck slave ends the run.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            k++;
            if (k > 20) begin
                err_total++;
                final_report();
            end
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Polls the state field; a state that never comes ends the run.
    task automatic wait_st(input int s, input int lim);
        int k;
        k = 0;
        do begin
            rd(`PMC_STATUS_OFS);
            k++;
            if (k > lim) begin
                err_total++;
                final_report();
            end
        end while (r[2:0] !== s[2:0]);
    endtask

    task automatic go_sleep();
        wr(`PMC_CTRL_OFS, 32'h0000_0001);
        wait_st(2, 20);
        core_pgood <= 1'b0;
        wait_st(3, 20);
        chk("wdog_asleep", watchdog_en, 1'b0);
        chk("clk_asleep", node_clk_en, 1'b0);
        chk("supply_asleep", core_supply_en, 1'b0);
        chk("reset_asleep", node_reset, 1'b1);
    endtask

    task automatic wake_done();
        core_pgood <= 1'b1;
        wait_st(0, 20);
        chk("wdog_awake", watchdog_en, 1'b1);
        chk("clk_awake", node_clk_en, 1'b1);
        chk("supply_awake", core_supply_en, 1'b1);
        chk("reset_awake", node_reset, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PMC_STATUS_OFS);
        chk("status_rst", r, 32'h0000_0000);
        rd(`PMC_INCR_OFS);
        chk("incr_rst", r, `PMC_INCR_RST);
        rd(`PMC_CMP_LO_OFS);
        chk("cmp_lo_rst", r, 32'hFFFF_FFFF);
        rd(`PMC_CMP_HI_OFS);
        chk("cmp_hi_rst", r, 32'hFFFF_FFFF);
        chk("wdog_rst", watchdog_en, 1'b1);
        rd(12'h040);
        chk("unmapped_err", e, 1'b1);
        chk("unmapped_rd", r, 32'h0000_0000);
        t1 = rnd();
        wr(`PMC_SLPCFG_OFS, t1);
        // The copy on the output pin lags the register by one clock.
        repeat (2) @(posedge pclk);
        chk("sleep_cfg", sleep_cfg, t1);
        rd(`PMC_RTC_LO_OFS);
        t1 = r;
        rd(`PMC_RTC_LO_OFS);
        chk("rtc_step", r - t1, 32'h0000_0003);
        for (int i = 0; i < 32; i++) begin
            dsm[i] = rnd();
            wr(`PMC_DSMEM_OFS + 12'(i * 4), dsm[i]);
        end
        // Pin wake with random pin and polarity; active level while awake is ignored.
        pin = int'(rnd() % 16);
        pol = int'(rnd() % 2);
        wake_pins <= {16{~pol[0]}};
        wr(`PMC_WAKE_CFG_OFS, 32'(pin) | (32'(pol) << 4) | 32'h0000_0020);
        wake_pins[pin] <= pol[0];
        repeat (4) rd(`PMC_STATUS_OFS);
        chk("no_wake_awake", r[2:0], 3'd0);
        wake_pins[pin] <= ~pol[0];
        go_sleep();
        wake_pins[pin] <= pol[0];
        wait_st(4, 20);
        wake_done();
        wake_pins[pin] <= ~pol[0];
        for (int i = 0; i < 32; i++) begin
            rd(`PMC_DSMEM_OFS + 12'(i * 4));
            chk("dsm_keep", r, dsm[i]);
        end
        // A short pin pulse during descent must still wake once asleep.
        wr(`PMC_CTRL_OFS, 32'h0000_0001);
        wait_st(2, 20);
        wake_pins[pin] <= pol[0];
        rd(`PMC_STATUS_OFS);
        chk("pend_seen", r[3], 1'b1);
        wake_pins[pin] <= ~pol[0];
        core_pgood <= 1'b0;
        wait_st(4, 20);
        wake_done();
        // Timer wake on the low-power clock; the big step jumps over the compare value.
        wr(`PMC_WAKE_CFG_OFS, 32'h0000_00C0);
        wr(`PMC_INCR_OFS, LP_INC);
        wr(`PMC_CMP_HI_OFS, 32'h0000_0000);
        wr(`PMC_CMP_LO_OFS, 32'h0040_0000);
        wr(`PMC_RTC_HI_OFS, 32'h0000_0000);
        wr(`PMC_RTC_LO_OFS, 32'h0000_0000);
        go_sleep();
        rd(`PMC_RTC_LO_OFS);
        t1 = r;
        repeat (700) @(posedge pclk);
        rd(`PMC_RTC_LO_OFS);
        chk("lp_step", 32'((r - t1 == LP_INC) || (r - t1 == 2 * LP_INC)), 32'h0000_0001);
        wait_st(4, 1500);
        wake_done();
        // Supply loss during descent forces a system reset and a return to awake.
        wr(`PMC_WAKE_CFG_OFS, 32'h0000_0000);
        wr(`PMC_CTRL_OFS, 32'h0000_0001);
        wait_st(2, 20);
        buck_pgood <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sys_reset !== 1'b1 && n < 8);
        chk("sys_reset", sys_reset, 1'b1);
        buck_pgood <= 1'b1;
        wait_st(0, 20);
        chk("fail_seen", r[4], 1'b1);
        final_report();
    end
endmodule // test_power_mode_controller
